// ---- rtl/pucse_pkg.sv ----
// constants shared by the user configuration group and its serial eeprom engine
// assumes a pci core that turns config cycles into one-cycle word strobes
package pucse_pkg;
  // ----------------------------------------------------------------
  // register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_SERIAL = 8'h40;
  localparam logic [7:0] OFF_LREQ = 8'h44;
  localparam logic [7:0] OFF_MCMD = 8'h48;
  localparam logic [7:0] OFF_DEBUG = 8'h4C;
  localparam logic [31:0] RST_SERIAL = 32'h0000001F;
  localparam logic [31:0] RST_LREQ = 32'h00000000;
  localparam logic [31:0] RST_MCMD = 32'h000007E6;
  localparam logic [31:0] RST_DEBUG = 32'h00000000;
  localparam logic [31:0] RST_IDS = 32'h00000000;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int GO_BIT = 24;
  localparam int OP_HI = 23;
  localparam int OP_LO = 16;
  localparam int ADDR_HI = 15;
  localparam int ADDR_LO = 8;
  localparam int DATA_HI = 7;
  localparam int DATA_LO = 0;
  localparam int LREQ_BIT = 0;
  localparam int WIN_EN_BIT = 17;
  localparam int WCMD_HI = 11;
  localparam int WCMD_LO = 8;
  localparam int RMULTI_HI = 7;
  localparam int RMULTI_LO = 4;
  localparam int RSINGLE_HI = 3;
  localparam int RSINGLE_LO = 0;
  // ----------------------------------------------------------------
  // serial opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;
  localparam logic [7:0] OP_ARRAY_READ = 8'h03;
  localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  // ----------------------------------------------------------------
  // serial clock timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int SCK_HALF_NS = 40;
  localparam logic [3:0] SCK_HALF_CYC =
    4'((SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  typedef enum logic [1:0] {
    PUCSE_IDLE = 2'b00,
    PUCSE_SETUP = 2'b01,
    PUCSE_SHIFT = 2'b11,
    PUCSE_FINISH = 2'b10
  } pucse_state_e;
endpackage

// ---- rtl/pucse_top.sv ----
// user configuration registers 40..4C: serial eeprom engine, request
// timing, master command select and initiator address capture
// assumes the pci core issues one-cycle config strobes on clock_i and
// reports master bus events as one-cycle pulses on the same clock
`timescale 1ns/10ps
// Contract
// - go bit self-clears when transfer ends
// - opcodes 02 write, 03 read array
// - opcodes 01, 04, 05, 06 supported
// - read byte appears in data field
// - hold off: request drops with frame start
// - hold on: request drops with frame end
// - window enable bit resets to zero
// - window enable loadable from eeprom and host
// - write command field resets to memory write
// - multi read field resets to read line
// - single read command field supplied
// - command fields writable any time, host write wins over boot load
// - debug register tracks next initiator address
// - failed transfer address kept in debug
// - board identifiers reloadable after reset
// - window disabled claims nothing
module pucse_top (
  input wire logic clock_i,
  input wire logic rst_i,
  // config access
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  // serial eeprom pins
  output logic spi_cs_n_o,
  output logic spi_sck_o,
  output logic spi_mosi_o,
  input wire logic spi_miso_i,
  // boot-time loads from the eeprom loader
  input wire logic boot_mcmd_load_i,
  input wire logic [31:0] boot_mcmd_i,
  input wire logic boot_id_load_i,
  input wire logic [31:0] boot_id_i,
  output logic [15:0] board_identifier_o,
  output logic [15:0] board_vendor_identifier_o,
  // master request control
  input wire logic master_want_i,
  input wire logic frame_start_i,
  input wire logic frame_end_i,
  output logic req_n_o,
  // master command fields and window enable
  output logic [3:0] master_write_cmd_o,
  output logic [3:0] master_read_multi_cmd_o,
  output logic [3:0] master_read_single_cmd_o,
  output logic second_window_enable_o,
  input wire logic second_window_enable_hit_i,
  output logic second_window_enable_claim_o,
  // initiator address capture
  input wire logic init_addr_valid_i,
  input wire logic [31:0] init_addr_i,
  input wire logic init_fail_i
);
  import pucse_pkg::*;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic eeprom_go;
  logic [7:0] eeprom_opcode;
  logic [7:0] eeprom_byte_addr;
  logic [7:0] eeprom_data_field;
  logic hold_request;
  logic [3:0] master_write_cmd;
  logic [3:0] master_read_multi_cmd;
  logic [3:0] master_read_single_cmd;
  logic second_window_enable;
  logic [31:0] debug_addr;
  logic debug_locked;
  logic [31:0] board_ids;
  pucse_state_e state;
  logic [3:0] div_cnt;
  logic [4:0] bits_left;
  logic [23:0] tx_shift;
  logic [7:0] rx_shift;
  logic rx_capture;
  logic miso_s1;
  logic miso_s2;
  logic miso_s3;
  logic miso_q;
  logic cs_n;
  logic sck;
  logic req_n;
  logic bus_owned;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire hit_serial = cfg_addr_i == OFF_SERIAL;
  wire hit_lreq = cfg_addr_i == OFF_LREQ;
  wire hit_mcmd = cfg_addr_i == OFF_MCMD;
  wire hit_debug = cfg_addr_i == OFF_DEBUG;
  // busy transfer freezes the access register
  wire wr_serial = cfg_wr_i && hit_serial && !eeprom_go;
  wire wr_lreq = cfg_wr_i && hit_lreq;
  wire wr_mcmd = cfg_wr_i && hit_mcmd;
  wire rd_debug = cfg_rd_i && hit_debug;

  // read data; unmapped offsets answer zero
  wire [31:0] serial_word = {7'h00, eeprom_go, eeprom_opcode, eeprom_byte_addr,
                             eeprom_data_field};
  wire [31:0] mcmd_word = {14'h0000, second_window_enable, 5'h00,
                           master_write_cmd, master_read_multi_cmd,
                           master_read_single_cmd};
  wire [31:0] rd_mux = hit_serial ? serial_word :
                       hit_lreq ? {31'h00000000, hold_request} :
                       hit_mcmd ? mcmd_word :
                       hit_debug ? debug_addr : 32'h00000000;

  // ----------------------------------------------------------------
  // transfer shape from the opcode
  // ----------------------------------------------------------------
  wire op_has_addr = eeprom_opcode == OP_ARRAY_WRITE ||
                     eeprom_opcode == OP_ARRAY_READ;
  wire op_has_tx = eeprom_opcode == OP_ARRAY_WRITE ||
                   eeprom_opcode == OP_STATUS_WRITE;
  wire op_has_rx = eeprom_opcode == OP_ARRAY_READ ||
                   eeprom_opcode == OP_STATUS_READ;
  // latch set/clear and unknown opcodes shift the opcode byte alone
  wire [4:0] op_bits = 5'd8 + (op_has_addr ? 5'd8 : 5'd0) +
                       ((op_has_tx || op_has_rx) ? 5'd8 : 5'd0);
  wire [23:0] tx_load = op_has_addr ?
                        {eeprom_opcode, eeprom_byte_addr, eeprom_data_field} :
                        {eeprom_opcode, eeprom_data_field, 8'h00};
  wire half_done = div_cnt == SCK_HALF_CYC - 4'd1;
  wire fall_now = state == PUCSE_SHIFT && half_done && sck;
  wire last_bit = bits_left == 5'd1;
  wire xfer_done = state == PUCSE_FINISH && half_done;

  // ----------------------------------------------------------------
  // access register: host fields and engine results
  // ----------------------------------------------------------------
  // go is only written while idle, so the engine's clear never collides
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      eeprom_go <= RST_SERIAL[GO_BIT];
      eeprom_opcode <= RST_SERIAL[OP_HI:OP_LO];
      eeprom_byte_addr <= RST_SERIAL[ADDR_HI:ADDR_LO];
      eeprom_data_field <= RST_SERIAL[DATA_HI:DATA_LO];
    end else if (wr_serial) begin
      eeprom_go <= cfg_wdata_i[GO_BIT];
      eeprom_opcode <= cfg_wdata_i[OP_HI:OP_LO];
      eeprom_byte_addr <= cfg_wdata_i[ADDR_HI:ADDR_LO];
      eeprom_data_field <= cfg_wdata_i[DATA_HI:DATA_LO];
    end else if (xfer_done) begin
      eeprom_go <= 1'b0;
      if (rx_capture) begin
        eeprom_data_field <= rx_shift;
      end
    end
  end

  // ----------------------------------------------------------------
  // miso synchroniser: three stages, change taken when two agree
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
      miso_s3 <= 1'b0;
      miso_q <= 1'b0;
    end else begin
      miso_s1 <= spi_miso_i;
      miso_s2 <= miso_s1;
      miso_s3 <= miso_s2;
      if (miso_s2 == miso_s3) begin
        miso_q <= miso_s3;
      end
    end
  end

  // ----------------------------------------------------------------
  // serial engine, mode 0: mosi moves on falling sck, eeprom samples rising
  // ----------------------------------------------------------------
  // miso is taken at the end of the high half, well after sync delay
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state <= PUCSE_IDLE;
      div_cnt <= 4'h0;
      bits_left <= 5'h00;
      tx_shift <= 24'h000000;
      rx_shift <= 8'h00;
      rx_capture <= 1'b0;
      cs_n <= 1'b1;
      sck <= 1'b0;
    end else begin
      div_cnt <= (state == PUCSE_IDLE || half_done) ? 4'h0 : div_cnt + 4'h1;
      case (state)
        PUCSE_IDLE: begin
          if (eeprom_go) begin
            state <= PUCSE_SETUP;
            cs_n <= 1'b0;
            tx_shift <= tx_load;
            bits_left <= op_bits;
            rx_capture <= op_has_rx;
          end
        end
        PUCSE_SETUP: begin
          if (half_done) begin
            state <= PUCSE_SHIFT;
          end
        end
        PUCSE_SHIFT: begin
          if (half_done) begin
            sck <= ~sck;
          end
          if (fall_now) begin
            tx_shift <= {tx_shift[22:0], 1'b0};
            rx_shift <= {rx_shift[6:0], miso_q};
            bits_left <= bits_left - 5'd1;
            if (last_bit) begin
              state <= PUCSE_FINISH;
            end
          end
        end
        PUCSE_FINISH: begin
          if (half_done) begin
            cs_n <= 1'b1;
            state <= PUCSE_IDLE;
          end
        end
        default: begin
          state <= PUCSE_IDLE;
          cs_n <= 1'b1;
          sck <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // request control and master command select
  // ----------------------------------------------------------------
  // frame_start_i/frame_end_i are registered in step with frame itself
  wire req_release = hold_request ? frame_end_i : frame_start_i;
  wire req_raise = master_want_i && !bus_owned && req_n && !frame_start_i;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      hold_request <= RST_LREQ[LREQ_BIT];
      req_n <= 1'b1;
      bus_owned <= 1'b0;
    end else begin
      if (wr_lreq) begin
        hold_request <= cfg_wdata_i[LREQ_BIT];
      end
      if (frame_start_i) begin
        bus_owned <= 1'b1;
      end else if (frame_end_i) begin
        bus_owned <= 1'b0;
      end
      if (!req_n && req_release) begin
        req_n <= 1'b1;
      end else if (req_raise) begin
        req_n <= 1'b0;
      end
    end
  end

  // host write takes priority over a boot load in the same cycle
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      second_window_enable <= RST_MCMD[WIN_EN_BIT];
      master_write_cmd <= RST_MCMD[WCMD_HI:WCMD_LO];
      master_read_multi_cmd <= RST_MCMD[RMULTI_HI:RMULTI_LO];
      master_read_single_cmd <= RST_MCMD[RSINGLE_HI:RSINGLE_LO];
    end else if (wr_mcmd) begin
      second_window_enable <= cfg_wdata_i[WIN_EN_BIT];
      master_write_cmd <= cfg_wdata_i[WCMD_HI:WCMD_LO];
      master_read_multi_cmd <= cfg_wdata_i[RMULTI_HI:RMULTI_LO];
      master_read_single_cmd <= cfg_wdata_i[RSINGLE_HI:RSINGLE_LO];
    end else if (boot_mcmd_load_i) begin
      second_window_enable <= boot_mcmd_i[WIN_EN_BIT];
      master_write_cmd <= boot_mcmd_i[WCMD_HI:WCMD_LO];
      master_read_multi_cmd <= boot_mcmd_i[RMULTI_HI:RMULTI_LO];
      master_read_single_cmd <= boot_mcmd_i[RSINGLE_HI:RSINGLE_LO];
    end
  end

  // ----------------------------------------------------------------
  // debug capture, identifiers, read port and window claim
  // ----------------------------------------------------------------
  // a failure freezes the captured address until software reads it
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      debug_addr <= RST_DEBUG;
      debug_locked <= 1'b0;
      board_ids <= RST_IDS;
      cfg_rdata_o <= 32'h00000000;
      second_window_enable_claim_o <= 1'b0;
    end else begin
      if (init_fail_i) begin
        debug_locked <= 1'b1;
      end else if (rd_debug) begin
        debug_locked <= 1'b0;
      end
      if (init_addr_valid_i && !debug_locked && !init_fail_i) begin
        debug_addr <= init_addr_i;
      end
      if (boot_id_load_i) begin
        board_ids <= boot_id_i;
      end
      if (cfg_rd_i) begin
        cfg_rdata_o <= rd_mux;
      end
      second_window_enable_claim_o <= second_window_enable_hit_i && second_window_enable;
    end
  end

  // ----------------------------------------------------------------
  // outputs, each straight from a flop
  // ----------------------------------------------------------------
  assign spi_cs_n_o = cs_n;
  assign spi_sck_o = sck;
  assign spi_mosi_o = tx_shift[23];
  assign req_n_o = req_n;
  assign master_write_cmd_o = master_write_cmd;
  assign master_read_multi_cmd_o = master_read_multi_cmd;
  assign master_read_single_cmd_o = master_read_single_cmd;
  assign second_window_enable_o = second_window_enable;
  assign board_identifier_o = board_ids[31:16];
  assign board_vendor_identifier_o = board_ids[15:0];

endmodule // pucse_top

// ---- tb/pucse_props.sv ----
// checker for the user configuration group, watching pucse_top ports only
// assumes the hold bit changes only through its own config word
`timescale 1ns/10ps
module pucse_props (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic spi_cs_n_o,
  input wire logic spi_sck_o,
  input wire logic boot_mcmd_load_i,
  input wire logic [31:0] boot_mcmd_i,
  input wire logic frame_start_i,
  input wire logic frame_end_i,
  input wire logic req_n_o,
  input wire logic [3:0] master_write_cmd_o,
  input wire logic [3:0] master_read_multi_cmd_o,
  input wire logic [3:0] master_read_single_cmd_o,
  input wire logic second_window_enable_o,
  input wire logic second_window_enable_hit_i,
  input wire logic second_window_enable_claim_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic hold;
  wire w48 = cfg_wr_i && cfg_addr_i == 8'h48;
  wire hen = second_window_enable_hit_i && second_window_enable_o;
  wire [12:0] wimg = {cfg_wdata_i[17], cfg_wdata_i[11:0]};
  wire [12:0] bimg = {boot_mcmd_i[17], boot_mcmd_i[11:0]};
  wire [12:0] cur = {second_window_enable_o, master_write_cmd_o, master_read_multi_cmd_o,
    master_read_single_cmd_o};
  // shadow of the hold bit: it picks which frame edge must drop the request
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) hold <= 1'b0;
    else if (cfg_wr_i && cfg_addr_i == 8'h44) hold <= cfg_wdata_i[0];
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  a_cmd_reset_vals: assert property ($fell(rst_i) |-> cur == 13'h07E6)
    else $error("command fields wrong after reset");
  a_cmd_host_write: assert property (w48 |=> cur == $past(wimg))
    else $error("command fields missed a host write");
  a_cmd_boot_load: assert property (boot_mcmd_load_i && !w48 |=> cur == $past(bimg))
    else $error("command fields missed a boot load");
  a_req_short_hold: assert property (!hold && frame_start_i && !req_n_o |=> req_n_o)
    else $error("request not dropped with frame start");
  a_req_long_hold: assert property (hold && frame_start_i && !req_n_o |=> !req_n_o)
    else $error("request dropped too early");
  a_req_end_drop: assert property (hold && frame_end_i && !req_n_o |=> req_n_o)
    else $error("request not dropped with frame end");
  a_claim_window: assert property (second_window_enable_claim_o == $past(hen))
    else $error("window claim does not follow hit and enable");
  a_sck_idle_low: assert property (spi_cs_n_o |-> !spi_sck_o)
    else $error("serial clock moves while deselected");
  a_cs_setup_low: assert property ($fell(spi_cs_n_o) |-> !spi_sck_o [*8])
    else $error("serial clock too soon after select");
endmodule // pucse_props
bind pucse_top pucse_props i_pucse_props (.clock_i, .rst_i, .cfg_wr_i, .cfg_addr_i, .cfg_wdata_i,
  .spi_cs_n_o, .spi_sck_o, .boot_mcmd_load_i, .boot_mcmd_i, .frame_start_i, .frame_end_i,
  .req_n_o, .master_write_cmd_o, .master_read_multi_cmd_o, .master_read_single_cmd_o,
  .second_window_enable_o, .second_window_enable_hit_i, .second_window_enable_claim_o);

// ---- tb/pucse_eeprom_model.sv ----
// behavioural serial eeprom: byte array, status byte and write latch
// assumes mode 0 framing, one command per chip select low period
`timescale 1ns/10ps
module pucse_eeprom_model (
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic mosi_i,
  output logic miso_o
);
  logic [7:0] mem [256];
  logic [7:0] st = 8'h00;
  logic [7:0] op;
  logic [7:0] ad;
  logic [7:0] dt;
  logic wel = 1'b0;
  int cnt = 0;
  wire [7:0] st_rd = {st[7:2], wel, 1'b0};
  initial miso_o = 1'b0;
  // shift in on the rising edge, msb first: opcode, address, data
  always @(posedge sck_i) begin
    if (!cs_n_i) begin
      cnt++;
      if (cnt <= 8) op = {op[6:0], mosi_i};
      else if (cnt <= 16) ad = {ad[6:0], mosi_i};
      else dt = {dt[6:0], mosi_i};
    end
  end
  // read bits change on the fall; otherwise the line keeps toggling so
  // that a stale level can never pass for data
  always @(negedge sck_i) begin
    if (!cs_n_i && op == 8'h03 && cnt >= 16 && cnt < 24) miso_o = mem[ad][23 - cnt];
    else if (!cs_n_i && op == 8'h05 && cnt >= 8 && cnt < 16) miso_o = st_rd[15 - cnt];
    else miso_o = ~miso_o;
  end
  // a command acts when deselected after its full length; writes clear the latch at any length past the opcode
  always @(posedge cs_n_i) begin
    if (op == 8'h06 && cnt == 8) wel = 1'b1;
    if (op == 8'h04 && cnt == 8) wel = 1'b0;
    if (op == 8'h01 && cnt == 16 && wel) st = ad;
    if (op == 8'h02 && cnt == 24 && wel) mem[ad] = dt;
    if ((op == 8'h01 || op == 8'h02) && cnt > 8) wel = 1'b0;
    cnt = 0;
    miso_o = ~miso_o;
  end
endmodule // pucse_eeprom_model

// ---- tb/test_pci_user_cfg_spi_eeprom.sv ----
// self-checking bench for pucse_top with a behavioural serial eeprom
// assumes one-clock config strobes and read data one clock later
`timescale 1ns/10ps
module test_pci_user_cfg_spi_eeprom;
  import pucse_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic cfg_wr_i = 1'b0;
  logic cfg_rd_i = 1'b0;
  logic [7:0] cfg_addr_i = 8'h00;
  logic [31:0] cfg_wdata_i = 32'h0;
  logic [31:0] cfg_rdata_o;
  logic spi_cs_n_o;
  logic spi_sck_o;
  logic spi_mosi_o;
  logic spi_miso_i;
  logic boot_mcmd_load_i = 1'b0;
  logic [31:0] boot_mcmd_i = 32'h0;
  logic boot_id_load_i = 1'b0;
  logic [31:0] boot_id_i = 32'h0;
  logic [15:0] board_identifier_o;
  logic [15:0] board_vendor_identifier_o;
  logic master_want_i = 1'b0;
  logic frame_start_i = 1'b0;
  logic frame_end_i = 1'b0;
  logic req_n_o;
  logic second_window_enable_hit_i = 1'b0;
  logic init_addr_valid_i = 1'b0;
  logic [31:0] init_addr_i = 32'h0;
  logic init_fail_i = 1'b0;
  logic [32:0] notes [$];
  logic rd_seen = 1'b0;
  logic [32:0] id_notes [$];
  logic id_seen = 1'b0;
  wire [31:0] ids_o = {board_identifier_o, board_vendor_identifier_o};
  int bad_count = 0;
  int tests_run = 0;
  pucse_top i_pucse_top (
    .clock_i, .rst_i, .cfg_wr_i, .cfg_rd_i, .cfg_addr_i, .cfg_wdata_i, .cfg_rdata_o,
    .spi_cs_n_o, .spi_sck_o, .spi_mosi_o, .spi_miso_i, .boot_mcmd_load_i, .boot_mcmd_i,
    .boot_id_load_i, .boot_id_i, .board_identifier_o, .board_vendor_identifier_o,
    .master_want_i, .frame_start_i, .frame_end_i, .req_n_o, .master_write_cmd_o(),
    .master_read_multi_cmd_o(), .master_read_single_cmd_o(), .second_window_enable_o(),
    .second_window_enable_hit_i, .second_window_enable_claim_o(), .init_addr_valid_i, .init_addr_i, .init_fail_i
  );
  pucse_eeprom_model i_pucse_eeprom_model (.cs_n_i(spi_cs_n_o), .sck_i(spi_sck_o),
    .mosi_i(spi_mosi_o), .miso_o(spi_miso_i));
  initial forever #2 clock_i = ~clock_i;
  // ------------------------------------------------------------
  // drivers, watcher and verdict
  // ------------------------------------------------------------
  // window hits arrive at random so the claim logic sees both cases
  always @(posedge clock_i) second_window_enable_hit_i <= 1'($urandom);
  task automatic close_out;
    $display("checks run %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [32:0] n, input logic [31:0] got);
    if (n[32]) begin
      tests_run++;
      if (got !== n[31:0]) begin
        bad_count++;
        $display("CHECK FAILED at %0t expected %h got %h", $time, n[31:0], got);
      end
    end
  endtask
  // the watcher pairs each read answer or id load with the oldest note
  always @(posedge clock_i) begin
    if (rd_seen && notes.size() > 0) chk(notes.pop_front(), cfg_rdata_o);
    rd_seen <= cfg_rd_i;
    if (id_seen && id_notes.size() > 0) chk(id_notes.pop_front(), ids_o);
    id_seen <= boot_id_load_i;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    cfg_wr_i <= 1'b1;
    cfg_addr_i <= a;
    cfg_wdata_i <= d;
    @(posedge clock_i);
    cfg_wr_i <= 1'b0;
  endtask
  // a poll read notes no expectation, its value is free
  task automatic rd(input logic [7:0] a, input logic ck, input logic [31:0] e);
    @(posedge clock_i);
    notes.push_back({ck, e});
    cfg_rd_i <= 1'b1;
    cfg_addr_i <= a;
    @(posedge clock_i);
    cfg_rd_i <= 1'b0;
  endtask
  // launch, try to disturb while busy, poll until done, check the word
  task automatic spi(input logic [7:0] op, input logic [7:0] a, input logic [7:0] d,
    input logic [7:0] e);
    int n;
    wr(OFF_SERIAL, {7'h00, 1'b1, op, a, d});
    wr(OFF_SERIAL, {7'h00, 1'b0, ~op, ~a, ~d});
    for (n = 0; n < 400; n++) begin
      rd(OFF_SERIAL, 1'b0, 32'h0);
      @(negedge clock_i);
      if (cfg_rdata_o[GO_BIT] === 1'b0) break;
    end
    if (n == 400) begin
      bad_count++;
      close_out();
    end
    rd(OFF_SERIAL, 1'b1, {8'h00, op, a, e});
  endtask
  task automatic ev(input logic [31:0] v, input logic vl, input logic fl);
    @(posedge clock_i);
    init_addr_i <= v;
    init_addr_valid_i <= vl;
    init_fail_i <= fl;
    @(posedge clock_i);
    init_addr_valid_i <= 1'b0;
    init_fail_i <= 1'b0;
  endtask
  initial begin
    logic [31:0] r;
    logic [7:0] a;
    logic [7:0] d;
    void'($urandom(32'h01A5));
    a = 8'($urandom);
    d = 8'($urandom);
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(OFF_SERIAL, 1'b1, 32'h0000001F);
    rd(OFF_LREQ, 1'b1, 32'h0);
    rd(OFF_MCMD, 1'b1, 32'h000007E6);
    rd(OFF_DEBUG, 1'b1, 32'h0);
    rd(8'h50, 1'b1, 32'h0);
    spi(OP_LATCH_SET, a, d, d);
    spi(OP_STATUS_READ, a, d, 8'h02);
    spi(OP_ARRAY_WRITE, a, d, d);
    spi(OP_STATUS_READ, a, d, 8'h00);
    spi(OP_ARRAY_READ, a, ~d, d);
    spi(OP_LATCH_SET, a, d, d);
    spi(OP_STATUS_WRITE, a, 8'h8C, 8'h8C);
    spi(OP_STATUS_READ, a, d, 8'h8C);
    spi(OP_LATCH_SET, a, d, d);
    spi(OP_LATCH_CLEAR, a, d, d);
    spi(8'h07, a, d, d);
    spi(OP_STATUS_READ, a, d, 8'h8C);
    for (int h = 0; h < 2; h++) begin
      wr(OFF_LREQ, 32'(h));
      rd(OFF_LREQ, 1'b1, 32'(h));
      master_want_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      frame_start_i <= 1'b1;
      @(posedge clock_i);
      frame_start_i <= 1'b0;
      master_want_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      frame_end_i <= 1'b1;
      @(posedge clock_i);
      frame_end_i <= 1'b0;
    end
    r = $urandom | 32'h00020000;
    wr(OFF_MCMD, r);
    rd(OFF_MCMD, 1'b1, r & 32'h00020FFF);
    r = $urandom;
    boot_mcmd_i <= r;
    boot_id_i <= ~r;
    id_notes.push_back({1'b1, ~r});
    boot_mcmd_load_i <= 1'b1;
    boot_id_load_i <= 1'b1;
    @(posedge clock_i);
    boot_mcmd_load_i <= 1'b0;
    boot_id_load_i <= 1'b0;
    rd(OFF_MCMD, 1'b1, r & 32'h00020FFF);
    r = $urandom;
    ev(r, 1'b1, 1'b0);
    rd(OFF_DEBUG, 1'b1, r);
    ev(r, 1'b0, 1'b1);
    ev(~r, 1'b1, 1'b0);
    rd(OFF_DEBUG, 1'b1, r);
    ev(~r, 1'b1, 1'b0);
    wr(OFF_DEBUG, r);
    rd(OFF_DEBUG, 1'b1, ~r);
    repeat (4) @(posedge clock_i);
    close_out();
  end
endmodule // test_pci_user_cfg_spi_eeprom
